// ==== srb_pkg.sv ====
package srb_pkg;

   // serial frame layout, LSB first position numbering
   localparam int          FRAME_W        = 16;
   localparam int          ADDR_LSB       = 0;
   localparam int          ADDR_W         = 7;
   localparam int          MODE_BIT       = 7;
   localparam int          DATA_LSB       = 8;
   localparam int          DATA_W         = 8;

   // recovery control and identification register offsets
   localparam logic [6:0]  OFS_REC_CTRL2  = 7'h3d;
   localparam logic [6:0]  OFS_REC_UPPER  = 7'h3e;
   localparam logic [6:0]  OFS_REC_LOWER  = 7'h3f;
   localparam logic [6:0]  OFS_FAMILY_ID  = 7'h7e;

   // recovery control fields and power-on values
   localparam int          CLK_SEL_LSB    = 0;
   localparam int          CLK_SEL_W      = 2;
   localparam logic [7:0]  RST_REC_CTRL2  = 8'h00;
   localparam logic [7:0]  RST_REC_UPPER  = 8'ha8;
   localparam logic [7:0]  RST_REC_LOWER  = 8'h98;

   // recovery clock select codes and resulting clock in MHz
   localparam logic [1:0]  CLK_SEL_80     = 2'h0;
   localparam logic [1:0]  CLK_SEL_40     = 2'h1;
   localparam logic [1:0]  CLK_SEL_20     = 2'h2;
   localparam logic [1:0]  CLK_SEL_10     = 2'h3;
   localparam logic [7:0]  REC_MHZ_80     = 8'h50;
   localparam logic [7:0]  REC_MHZ_40     = 8'h28;
   localparam logic [7:0]  REC_MHZ_20     = 8'h14;
   localparam logic [7:0]  REC_MHZ_10     = 8'h0a;

   // latched status registers
   localparam int          NSTAT          = 14;
   localparam int          STAT_DEVICE    = 3;   // index of device info status
   localparam logic [7:0]  STAT_RESET     = 8'h00;

   localparam logic [6:0]  STAT_ADDR [NSTAT] = '{
      7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47,
      7'h48, 7'h54, 7'h55, 7'h70, 7'h71, 7'h72, 7'h73};

   // read-clear bits of each status register
   localparam logic [7:0]  STAT_RC_MASK [NSTAT] = '{
      8'h63, 8'h9d, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   // read-only live bits; bits in neither mask are reserved and read 0
   localparam logic [7:0]  STAT_RO_MASK [NSTAT] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage : srb_pkg

// ==== srb_status_cdr_bank.sv ====
// Notes on behaviour
// - the two-bit recovery clock select picks 80, 40, 20 or 10 MHz for codes 00 to 11.
// - an 8-bit read-write upper limit clamps any tracked bit length above it.
// - an 8-bit read-write lower limit clamps a tracked bit length below it unless that length is also above the upper limit.
// - power-on or soft reset loads a8 into the upper limit and 98 into the lower limit.
// - each command is 16 bits, address plus mode bit in the first byte, data in the second.
// - data bits D0 to D7 sit at frame bit positions 8 to 15.
// - frame bit 7 low returns the addressed status byte and changes nothing.
// - frame bit 7 high clears the clearable flags of the addressed status register as a whole byte.
// - read-only and reserved bits ignore clears, read-clear bits are reset by a clear.
// - latched flags never clear on their own, only the watchdog failure count may change by itself.
// - status registers decode at 40 to 44, 46 to 48, 54 and 55, selective wake status at 70 to 73, identification at 7e.
// - the recovery clock select lives in bits 1:0 of recovery control two and is read-write.
`timescale 1ns/100ps

module srb_status_cdr_bank
   import srb_pkg::*;
#(
   parameter int         BTL_W     = 8,
   parameter logic [7:0] FAMILY_ID = 8'h5a   // arbitrary value
) (
   // clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_soft_rst,
   // command frame from the serial front end
   input  wire logic                  i_frame_valid,
   input  wire logic [FRAME_W-1:0]    i_frame,
   output      logic                  o_resp_valid,
   output      logic [DATA_W-1:0]     o_resp_data,
   output      logic                  o_resp_unmapped,
   // status sources
   input  wire logic [NSTAT*8-1:0]    i_stat_event,
   input  wire logic [NSTAT*8-1:0]    i_stat_level,
   output      logic                  o_wd_count_clear,
   // recovery unit
   output      logic [CLK_SEL_W-1:0]  o_recovery_clock_select,
   output      logic [7:0]            o_recovery_clk_mhz,
   output      logic [BTL_W-1:0]      o_recovery_upper_bound,
   output      logic [BTL_W-1:0]      o_recovery_lower_bound,
   input  wire logic                  i_track_valid,
   input  wire logic [BTL_W-1:0]      i_tracked_bit_length,
   output      logic [BTL_W-1:0]      o_clamped_bit_length,
   output      logic                  o_clamp_high,
   output      logic                  o_clamp_low
);

   // the limit registers are one data byte wide
   generate
      if (BTL_W != DATA_W) begin : g_bad_width
         $error("srb_status_cdr_bank: BTL_W must equal the data byte width");
      end
   endgenerate

   // frame fields
   logic [ADDR_W-1:0]  frm_addr;
   logic               frm_mode;
   logic [DATA_W-1:0]  frm_data;

   // slice the command word, address and mode first
   assign frm_addr = i_frame[ADDR_LSB +: ADDR_W];
   assign frm_mode = i_frame[MODE_BIT];
   assign frm_data = i_frame[DATA_LSB +: DATA_W];

   // recovery control registers
   logic [CLK_SEL_W-1:0]  clk_sel_r;
   logic [CLK_SEL_W-1:0]  clk_sel_nxt;
   logic [DATA_W-1:0]     upper_r;
   logic [DATA_W-1:0]     upper_nxt;
   logic [DATA_W-1:0]     lower_r;
   logic [DATA_W-1:0]     lower_nxt;
   logic                  ctrl_wr;

   // control registers take the data byte when the mode bit is set
   assign ctrl_wr = i_frame_valid & frm_mode;

   // next values; soft reset reloads the power-on values
   always_comb begin
      clk_sel_nxt = clk_sel_r;
      upper_nxt   = upper_r;
      lower_nxt   = lower_r;
      if (i_soft_rst) begin
         clk_sel_nxt = RST_REC_CTRL2[CLK_SEL_LSB +: CLK_SEL_W];
         upper_nxt   = RST_REC_UPPER;
         lower_nxt   = RST_REC_LOWER;
      end else if (ctrl_wr) begin
         case (frm_addr)
            OFS_REC_CTRL2: begin
               clk_sel_nxt = frm_data[CLK_SEL_LSB +: CLK_SEL_W];
            end
            OFS_REC_UPPER: begin
               upper_nxt = frm_data;
            end
            OFS_REC_LOWER: begin
               lower_nxt = frm_data;
            end
            default: begin
               clk_sel_nxt = clk_sel_r;
            end
         endcase
      end
   end

   // register the control group; a restart without reset keeps whatever
   // the limits held, only reset and soft reset load the power-on values
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         clk_sel_r <= RST_REC_CTRL2[CLK_SEL_LSB +: CLK_SEL_W];
         upper_r   <= RST_REC_UPPER;
         lower_r   <= RST_REC_LOWER;
      end else begin
         clk_sel_r <= clk_sel_nxt;
         upper_r   <= upper_nxt;
         lower_r   <= lower_nxt;
      end
   end

   // control outputs straight from flip-flops
   assign o_recovery_clock_select = clk_sel_r;
   assign o_recovery_upper_bound  = upper_r;
   assign o_recovery_lower_bound  = lower_r;

   // recovery clock rate and bit-length clamp
   logic [7:0]        mhz_nxt;
   logic [7:0]        mhz_r;
   logic [BTL_W-1:0]  clamp_nxt;
   logic [BTL_W-1:0]  clamp_r;
   logic              hi_nxt;
   logic              hi_r;
   logic              lo_nxt;
   logic              lo_r;

   // clock select decode; software keeps the ratio to baud within 80..160
   always_comb begin
      case (clk_sel_r)
         CLK_SEL_80: mhz_nxt = REC_MHZ_80;
         CLK_SEL_40: mhz_nxt = REC_MHZ_40;
         CLK_SEL_20: mhz_nxt = REC_MHZ_20;
         CLK_SEL_10: mhz_nxt = REC_MHZ_10;
         default:    mhz_nxt = REC_MHZ_80;
      endcase
   end

   // clamp the tracked length; upper wins if software crosses the limits
   // comparisons are unsigned, the lengths are counts of clock periods
   always_comb begin
      clamp_nxt = clamp_r;
      hi_nxt    = hi_r;
      lo_nxt    = lo_r;
      if (i_track_valid) begin
         hi_nxt    = 1'b0;
         lo_nxt    = 1'b0;
         clamp_nxt = i_tracked_bit_length;
         if (i_tracked_bit_length > upper_r) begin
            clamp_nxt = upper_r;
            hi_nxt    = 1'b1;
         end else if (i_tracked_bit_length < lower_r) begin
            clamp_nxt = lower_r;
            lo_nxt    = 1'b1;
         end
      end
   end

   // register the clock rate
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         mhz_r <= REC_MHZ_80;
      end else begin
         mhz_r <= mhz_nxt;
      end
   end

   // register the clamp result; soft reset leaves the last sample alone
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         clamp_r <= RST_REC_LOWER;
         hi_r    <= 1'b0;
         lo_r    <= 1'b0;
      end else begin
         clamp_r <= clamp_nxt;
         hi_r    <= hi_nxt;
         lo_r    <= lo_nxt;
      end
   end

   // recovery outputs straight from flip-flops
   assign o_recovery_clk_mhz   = mhz_r;
   assign o_clamped_bit_length = clamp_r;
   assign o_clamp_high         = hi_r;
   assign o_clamp_low          = lo_r;

   // latched status registers
   logic [7:0]        stat_val [NSTAT];
   logic [NSTAT-1:0]  stat_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NSTAT; gi++) begin : g_stat
         logic [7:0]  lat_r;
         logic [7:0]  lat_nxt;
         logic        clr;

         // address match and clear strobe of this register
         assign stat_hit[gi] = (frm_addr == STAT_ADDR[gi]);
         assign clr          = i_frame_valid & frm_mode & stat_hit[gi];

         // set beats clear so an event in the clear cycle survives
         always_comb begin
            lat_nxt = lat_r;
            if (i_soft_rst) begin
               lat_nxt = STAT_RESET;
            end else begin
               if (clr) begin
                  lat_nxt = lat_r & ~STAT_RC_MASK[gi];
               end
               lat_nxt = lat_nxt | (i_stat_event[gi*8 +: 8] & STAT_RC_MASK[gi]);
            end
         end

         // register the latch
         always_ff @(posedge i_core_clk) begin
            if (!i_rstn) begin
               lat_r <= STAT_RESET;
            end else begin
               lat_r <= lat_nxt;
            end
         end

         // reserved bits read zero, live bits bypass the latch
         assign stat_val[gi] = (lat_r & STAT_RC_MASK[gi])
                             | (i_stat_level[gi*8 +: 8] & STAT_RO_MASK[gi]);
      end
   endgenerate

   // the watchdog failure count is kept outside; a clear here restarts it
   // in the same cycle as the latched bits of that register
   assign o_wd_count_clear = i_frame_valid & frm_mode & stat_hit[STAT_DEVICE];

   // response byte: contents before any clear of the same frame
   logic [DATA_W-1:0]  rd_byte;
   logic               rd_miss;
   logic [DATA_W-1:0]  resp_data_r;
   logic [DATA_W-1:0]  resp_data_nxt;
   logic               resp_miss_r;
   logic               resp_miss_nxt;
   logic               resp_vld_r;
   logic               resp_vld_nxt;

   // address decode; reading never alters any bit
   // a hole answers zero and raises the unmapped flag
   always_comb begin
      rd_byte = '0;
      rd_miss = 1'b0;
      case (frm_addr)
         OFS_REC_CTRL2: rd_byte = {{(DATA_W-CLK_SEL_W){1'b0}}, clk_sel_r};
         OFS_REC_UPPER: rd_byte = upper_r;
         OFS_REC_LOWER: rd_byte = lower_r;
         OFS_FAMILY_ID: rd_byte = FAMILY_ID;
         default: begin
            rd_miss = ~(|stat_hit);
            for (int k = 0; k < NSTAT; k++) begin
               if (stat_hit[k]) begin
                  rd_byte = stat_val[k];
               end
            end
         end
      endcase
   end

   // one answer per frame, one cycle after it
   always_comb begin
      resp_vld_nxt  = i_frame_valid;
      resp_data_nxt = resp_data_r;
      resp_miss_nxt = resp_miss_r;
      if (i_frame_valid) begin
         resp_data_nxt = rd_byte;
         resp_miss_nxt = rd_miss;
      end
   end

   // register the answer; soft reset leaves it alone
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         resp_vld_r  <= 1'b0;
         resp_data_r <= '0;
         resp_miss_r <= 1'b0;
      end else begin
         resp_vld_r  <= resp_vld_nxt;
         resp_data_r <= resp_data_nxt;
         resp_miss_r <= resp_miss_nxt;
      end
   end

   // answer outputs straight from flip-flops
   assign o_resp_valid    = resp_vld_r;
   assign o_resp_data     = resp_data_r;
   assign o_resp_unmapped = resp_miss_r;

endmodule : srb_status_cdr_bank

// ==== srb_bank_checker.sv ====
`timescale 1ns/100ps
module srb_bank_checker
   import srb_pkg::*;
#(
   parameter int BTL_W = 8
) (
   // clock, reset, frame port
   input wire logic                 i_core_clk,
   input wire logic                 i_rstn,
   input wire logic                 i_soft_rst,
   input wire logic                 i_frame_valid,
   input wire logic [FRAME_W-1:0]   i_frame,
   input wire logic                 o_resp_valid,
   input wire logic [DATA_W-1:0]    o_resp_data,
   input wire logic                 o_resp_unmapped,
   input wire logic                 o_wd_count_clear,
   // recovery unit
   input wire logic [CLK_SEL_W-1:0] o_recovery_clock_select,
   input wire logic [7:0]           o_recovery_clk_mhz,
   input wire logic [BTL_W-1:0]     o_recovery_upper_bound,
   input wire logic [BTL_W-1:0]     o_recovery_lower_bound,
   input wire logic                 i_track_valid,
   input wire logic [BTL_W-1:0]     i_tracked_bit_length,
   input wire logic [BTL_W-1:0]     o_clamped_bit_length
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   // data byte as a plain net so $past sees a signal
   wire logic [DATA_W-1:0] frame_data = i_frame[DATA_LSB +: DATA_W];

   // frame taken at an address and mode, no soft reset alongside
   sequence s_take(a, m);
      i_frame_valid && !i_soft_rst && i_frame[6:0] == a && i_frame[MODE_BIT] == m;
   endsequence

   resp_pulse_a: assert property (i_frame_valid |=> o_resp_valid)
      else $error("no response after frame");
   upper_write_a: assert property (s_take(OFS_REC_UPPER, 1'b1) |=>
      o_recovery_upper_bound == $past(frame_data)) else $error("upper limit not written");
   lower_write_a: assert property (s_take(OFS_REC_LOWER, 1'b1) |=>
      o_recovery_lower_bound == $past(frame_data)) else $error("lower limit not written");
   clk_map_a: assert property (o_recovery_clk_mhz == (($past(o_recovery_clock_select) == 2'h0) ? 8'h50 :
      ($past(o_recovery_clock_select) == 2'h1) ? 8'h28 : ($past(o_recovery_clock_select) == 2'h2) ? 8'h14 : 8'h0a))
      else $error("recovery clock rate wrong");
   reset_vals_a: assert property ($rose(i_rstn) |-> o_recovery_upper_bound == 8'ha8 &&
      o_recovery_lower_bound == 8'h98 && o_recovery_clock_select == 2'h0) else $error("bad reset values");
   clamp_out_a: assert property (i_track_valid |=> o_clamped_bit_length ==
      (($past(i_tracked_bit_length) > $past(o_recovery_upper_bound)) ? $past(o_recovery_upper_bound) :
      ($past(i_tracked_bit_length) < $past(o_recovery_lower_bound)) ? $past(o_recovery_lower_bound) :
      $past(i_tracked_bit_length))) else $error("clamped length wrong");
   unmapped_a: assert property (s_take(7'h45, 1'b0) |=> o_resp_unmapped && o_resp_data == 8'h00)
      else $error("hole address answered");
   wd_clear_a: assert property (o_wd_count_clear == (i_frame_valid && i_frame[MODE_BIT] && i_frame[6:0] == 7'h43))
      else $error("watchdog count clear wrong");
endmodule : srb_bank_checker

// ==== srb_host_model.sv ====
`timescale 1ns/100ps
module srb_host_model
   import srb_pkg::*;
(
   // clock and answer
   input  wire logic               i_core_clk,
   input  wire logic               i_resp_valid,
   input  wire logic [DATA_W-1:0]  i_resp_data,
   // command frame
   output      logic               o_frame_valid,
   output      logic [FRAME_W-1:0] o_frame
);
   initial begin
      o_frame_valid = 1'b0;
      o_frame       = '0;
   end

   // whole frame: address and mode byte, then data byte
   task automatic xfer(input logic [6:0] a, input logic m, input logic [7:0] d,
                       output logic [7:0] r, output logic v);
      @(posedge i_core_clk);
      o_frame_valid <= 1'b1;
      o_frame       <= {d, m, a};
      @(posedge i_core_clk);
      o_frame_valid <= 1'b0;
      o_frame       <= ~{d, m, a};   // idle lines never hold the old frame
      // the answer was launched by this edge and stands for one cycle only
      #1;
      r = i_resp_data;
      v = i_resp_valid;
   endtask : xfer

   // recommended limits for ratio 160 or 80 only
   task automatic program_rec(input logic [1:0] sel, input logic r160);
      logic [7:0] r;
      logic       v;
      xfer(OFS_REC_CTRL2, 1'b1, {6'h00, sel}, r, v);
      xfer(OFS_REC_UPPER, 1'b1, r160 ? 8'ha8 : 8'h54, r, v);
      xfer(OFS_REC_LOWER, 1'b1, r160 ? 8'h98 : 8'h4c, r, v);
   endtask : program_rec
endmodule : srb_host_model

// ==== srb_status_cdr_bank_tb_top.sv ====
`timescale 1ns/100ps
module srb_status_cdr_bank_tb_top;
   import srb_pkg::*;
   localparam logic [7:0] FAM_ID = 8'h3c;   // arbitrary value
   localparam logic [6:0] HOLES [3] = '{7'h45, 7'h74, 7'h7f};
   logic                  clk, rstn, soft_rst, fv, resp_v, unm, trk_v, c_hi, c_lo, v;
   logic [FRAME_W-1:0]    frame;
   logic [NSTAT*8-1:0]    ev, lvl;
   logic [1:0]            sel;
   logic [7:0]            resp_d, mhz, up, lo, trk, clmp, r, a8, b8, x, e;
   logic [7:0]            mhz_tab [4] = '{8'h50, 8'h28, 8'h14, 8'h0a};
   logic [31:0]           seed = 32'hf3d4_d612;
   int                    num_errors = 0;
   int                    num_checks = 0;
   int                    cyc = 0;

   srb_status_cdr_bank #(.BTL_W(8), .FAMILY_ID(FAM_ID)) i_srb_status_cdr_bank (
      .i_core_clk(clk), .i_rstn(rstn), .i_soft_rst(soft_rst), .i_frame_valid(fv), .i_frame(frame),
      .o_resp_valid(resp_v), .o_resp_data(resp_d), .o_resp_unmapped(unm), .i_stat_event(ev),
      .i_stat_level(lvl), .o_wd_count_clear(), .o_recovery_clock_select(sel), .o_recovery_clk_mhz(mhz),
      .o_recovery_upper_bound(up), .o_recovery_lower_bound(lo), .i_track_valid(trk_v),
      .i_tracked_bit_length(trk), .o_clamped_bit_length(clmp), .o_clamp_high(c_hi), .o_clamp_low(c_lo));
   srb_host_model i_srb_host_model (.i_core_clk(clk), .i_resp_valid(resp_v), .i_resp_data(resp_d),
      .o_frame_valid(fv), .o_frame(frame));

   // 40 MHz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd
   function automatic logic [7:0] stat_exp(input int k, input logic [7:0] ee, l);
      return (ee & STAT_RC_MASK[k]) | (l & STAT_RO_MASK[k]);
   endfunction : stat_exp
   task automatic rw(input logic [6:0] a, input logic m, input logic [7:0] d);
      i_srb_host_model.xfer(a, m, d, r, v);
   endtask : rw
   task automatic check(input string n, input logic [7:0] ex, input logic [7:0] got);
      num_checks++;
      if (got !== ex) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, ex, got);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      {rstn, soft_rst, trk_v, trk, ev, lvl} = '0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rw(OFS_REC_UPPER, 1'b0, 8'h00);
      check("upper", 8'ha8, r);
      check("resp valid", 8'h01, {7'h0, v});
      rw(OFS_REC_LOWER, 1'b0, 8'h00);
      check("lower", 8'h98, r);
      // every select code, limits from the recommended pairs
      for (int i = 0; i < 6; i++) begin
         i_srb_host_model.program_rec(2'((i + 1) / 2), i % 2 == 0);
         rw(OFS_REC_CTRL2, 1'b0, 8'h00);
         check("ctrl2", 8'((i + 1) / 2), r);
         check("clk mhz", mhz_tab[(i + 1) / 2], mhz);
         check("clk select", 8'((i + 1) / 2), {6'h0, sel});
         check("upper", (i % 2 == 0) ? 8'ha8 : 8'h54, up);
         check("lower", (i % 2 == 0) ? 8'h98 : 8'h4c, lo);
      end
      // random limits, crossing ones too, sample sometimes on the limit
      for (int i = 0; i < 24; i++) begin
         a8 = rnd();
         b8 = rnd();
         x  = rnd();
         if (i % 6 == 0) x = a8;
         rw(OFS_REC_UPPER, 1'b1, a8);
         rw(OFS_REC_LOWER, 1'b1, b8);
         check("upper", a8, up);
         @(posedge clk);
         trk_v <= 1'b1;
         trk   <= x;
         @(posedge clk);
         trk_v <= 1'b0;
         trk   <= ~x;
         @(posedge clk);
         #1;
         check("clamped", (x > a8) ? a8 : (x < b8) ? b8 : x, clmp);
         check("clamp high", {7'h0, x > a8}, {7'h0, c_hi});
         check("clamp low", {7'h0, x <= a8 && x < b8}, {7'h0, c_lo});
      end
      // latched flags: one event pulse, read twice, clear, read
      for (int k = 0; k < NSTAT; k++) begin
         a8 = rnd();
         b8 = rnd();
         @(posedge clk);
         ev[8*k +: 8]  <= a8;
         lvl[8*k +: 8] <= b8;
         @(posedge clk);
         ev <= '0;
         e = stat_exp(k, a8, b8);
         rw(STAT_ADDR[k], 1'b0, 8'h00);
         check("status", e, r);
         rw(STAT_ADDR[k], 1'b0, 8'h00);
         check("status reread", e, r);
         rw(STAT_ADDR[k], 1'b1, 8'h00);
         check("status before clear", e, r);
         rw(STAT_ADDR[k], 1'b0, 8'h00);
         check("status after clear", stat_exp(k, 8'h00, b8), r);
      end
      // an event in the very cycle of a clear survives it
      fork
         rw(STAT_ADDR[0], 1'b1, 8'h00);
         begin
            @(posedge clk);
            ev[7:0] <= 8'hff;
            @(posedge clk);
            ev[7:0] <= 8'h00;
         end
      join
      rw(STAT_ADDR[0], 1'b0, 8'h00);
      check("set beats clear", STAT_RC_MASK[0], r);
      foreach (HOLES[j]) begin
         rw(HOLES[j], 1'b0, 8'h00);
         check("hole unmapped", 8'h01, {7'h0, unm});
         check("hole data", 8'h00, r);
      end
      rw(OFS_FAMILY_ID, 1'b1, 8'hff);
      rw(OFS_FAMILY_ID, 1'b0, 8'h00);
      check("family id", FAM_ID, r);
      check("family mapped", 8'h00, {7'h0, unm});
      // soft reset reloads the limits
      rw(OFS_REC_UPPER, 1'b1, 8'h11);
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      rw(OFS_REC_UPPER, 1'b0, 8'h00);
      check("upper after soft reset", 8'ha8, r);
      rw(OFS_REC_LOWER, 1'b0, 8'h00);
      check("lower after soft reset", 8'h98, r);
      rw(OFS_REC_CTRL2, 1'b0, 8'h00);
      check("ctrl2 after soft reset", 8'h00, r);
      rw(STAT_ADDR[0], 1'b0, 8'h00);
      check("status after soft reset", 8'h00, r);
      final_report();
   end
endmodule : srb_status_cdr_bank_tb_top

bind srb_status_cdr_bank srb_bank_checker #(.BTL_W(BTL_W)) i_srb_bank_checker (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_soft_rst(i_soft_rst), .i_frame_valid(i_frame_valid),
   .i_frame(i_frame), .o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data),
   .o_resp_unmapped(o_resp_unmapped), .o_wd_count_clear(o_wd_count_clear),
   .o_recovery_clock_select(o_recovery_clock_select), .o_recovery_clk_mhz(o_recovery_clk_mhz),
   .o_recovery_upper_bound(o_recovery_upper_bound), .o_recovery_lower_bound(o_recovery_lower_bound),
   .i_track_valid(i_track_valid), .i_tracked_bit_length(i_tracked_bit_length),
   .o_clamped_bit_length(o_clamped_bit_length));
